// [dv/ecc_chk.sv]
// Checker: bus answer, reset state, trigger width and readback
`timescale 1ns/1ps
module ecc_chk
   import ecc_pkg::*;
(
   input wire logic        I_CLK,
   input wire logic        I_RST_B,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        O_TRIG,
   input wire logic        O_IRQ
);
   logic [31:0] tw_r;
   logic [1:0]  msk_r;
   logic [9:0]  ctl_r;
   logic [2:0]  flt_r;
   logic        wph_r;
   logic [7:0]  wad_r;
   logic [31:0] hi_r;
   wire         acc = HSEL && HREADY && HTRANS[1];
   // Mirrors of written fields; self-clearing bits left out
   always_ff @(posedge I_CLK)
   begin
      wph_r <= acc && HWRITE;
      wad_r <= HADDR[7:0];
      hi_r  <= O_TRIG ? hi_r + 32'h1 : 32'h0;
      if (!I_RST_B)
      begin
         tw_r  <= TRIG_W_RST;
         msk_r <= 2'h0;
         ctl_r <= CTRL_RST[9:0];
         flt_r <= FILT_RST;
      end
      else if (wph_r)
      begin
         tw_r  <= (wad_r == ADDR_TRIG_W) ? HWDATA : tw_r;
         msk_r <= (wad_r == ADDR_MASK) ? HWDATA[1:0] : msk_r;
         ctl_r <= (wad_r == ADDR_CTRL) ? HWDATA[9:0] : ctl_r;
         flt_r <= (wad_r == ADDR_FILT) ? HWDATA[2:0] : flt_r;
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_rd(logic [7:0] a);
      acc && !HWRITE && HADDR == {24'h0, a};
   endsequence
   property p_rsp;
      HREADYOUT && !HRESP;
   endproperty
   property p_rst;
      disable iff (1'h0) !I_RST_B |=> !O_TRIG && !O_IRQ && HRDATA == 32'h0;
   endproperty
   property p_irq_off;
      msk_r == 2'h0 |-> !O_IRQ;
   endproperty
   property p_trig_w;
      $fell(O_TRIG) && $past(I_RST_B) |-> hi_r == tw_r;
   endproperty
   property p_tw_rd;
      s_rd(ADDR_TRIG_W) |=> HRDATA == tw_r;
   endproperty
   property p_ctl_rd;
      s_rd(ADDR_CTRL) |=> HRDATA[9:0] == ctl_r;
   endproperty
   property p_flt_rd;
      s_rd(ADDR_FILT) |=> HRDATA[2:0] == flt_r;
   endproperty
   property p_unmap;
      acc && !HWRITE && HADDR >= 32'h24 && HADDR < 32'h100 |=> HRDATA == 32'h0;
   endproperty
   a_rsp: assert property (p_rsp) else $error("bus answer not ready or not okay");
   a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
   a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
   a_trig_w: assert property (p_trig_w) else $error("trigger width wrong");
   a_tw_rd: assert property (p_tw_rd) else $error("width readback wrong");
   a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
   a_flt_rd: assert property (p_flt_rd) else $error("filter readback wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : ecc_chk

// [dv/ecc_enc_model.sv]
// Encoder model: drives phase, index and home switch pins
`timescale 1ns/1ps
module ecc_enc_model (
   input  wire logic i_clk,
   output logic      o_a,
   output logic      o_b,
   output logic      o_z,
   output logic      o_home
);
   int ph = 0;
   initial {o_home, o_z, o_b, o_a} = 4'h0;
   // Change after an edge, then hold so the filter can see the level
   task automatic put(input logic [3:0] v, input int n);
      @(posedge i_clk);
      {o_home, o_z, o_b, o_a} <= v;
      repeat (n) @(posedge i_clk);
   endtask : put
   // Forward means A leads B; one level change per step
   task automatic quad(input bit fwd, input int k);
      repeat (k)
      begin
         ph = (fwd ? ph + 1 : ph + 3) % 4;
         put({o_home, o_z, ph[1], ph[0] ^ ph[1]}, 20);
      end
   endtask : quad
endmodule : ecc_enc_model

// [dv/ecc_top_bench.sv]
// Testbench: counter channel fed by an encoder model, registers over AHB-Lite
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module ecc_top_bench
   import ecc_pkg::*;
;
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        a, b, z, home, trig, irq;
   int          fails = 0;
   int          compares = 0;
   int          tcnt = 0;
   ecc_top ecc_top_inst (.I_CLK(clk), .I_RST_B(rst_b), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .I_PHASE_A(a), .I_PHASE_B(b), .I_PHASE_Z(z), .I_HOME_SW(home), .O_TRIG(trig), .O_IRQ(irq));
   ecc_enc_model ecc_enc_model_inst (.i_clk(clk), .o_a(a), .o_b(b), .o_z(z), .o_home(home));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (trig === 1'h1) tcnt++;
   task automatic close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // Address phase held until ready, then data phase held until ready
   task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, ad};
      do @(posedge clk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'h1);
   endtask : xfer
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      xfer(1'h1, ad, d);
   endtask : wr
   task automatic rc(input logic [7:0] ad, input logic [31:0] e);
      xfer(1'h0, ad, 32'h0);
      `CHK($sformatf("reg %h", ad), e, hrdata)
   endtask : rc
   task automatic pin(input logic [3:0] v, input int n);
      ecc_enc_model_inst.put(v, n);
   endtask : pin
   task automatic t_reset;
      rc(ADDR_CTRL, CTRL_RST);
      rc(ADDR_FILT, 32'h1);
      rc(ADDR_COUNT, 32'h0);
      rc(ADDR_CMP, 32'hFFFF_FFFF);
      rc(ADDR_TRIG_W, TRIG_W_RST);
      rc(ADDR_HOME, 32'h0001_0001);
      rc(ADDR_STAT, 32'h0);
      rc(ADDR_MASK, 32'h0);
      rc(8'h40, 32'h0);
      $display("test reset done");
   endtask : t_reset
   // Sub-microsecond pulse must vanish at the reset rate
   task automatic t_filt;
      wr(ADDR_CTRL, 32'h1);
      pin(4'h1, 30);
      pin(4'h0, 200);
      rc(ADDR_COUNT, 32'h0);
      pin(4'h1, 200);
      pin(4'h0, 200);
      rc(ADDR_COUNT, 32'h1);
      wr(ADDR_FILT, 32'h5);
      pin(4'h2, 20);
      pin(4'h0, 20);
      rc(ADDR_COUNT, 32'h0);
      $display("test filter and dual done");
   endtask : t_filt
   task automatic t_single;
      wr(ADDR_CTRL, 32'h2);
      pin(4'h2, 20);
      repeat (2)
      begin
         pin(4'h3, 20);
         pin(4'h2, 20);
      end
      rc(ADDR_COUNT, 32'h2);
      pin(4'h0, 20);
      pin(4'h1, 20);
      pin(4'h0, 20);
      rc(ADDR_COUNT, 32'h1);
      $display("test single done");
   endtask : t_single
   task automatic t_quad;
      for (int r = 0; r < 3; r++)
      begin
         wr(ADDR_CTRL, 32'(r) << CTRL_RATE_LSB);
         wr(ADDR_COUNT, 32'h0);
         ecc_enc_model_inst.quad(1'h1, 4);
         rc(ADDR_COUNT, 32'h1 << r);
         ecc_enc_model_inst.quad(1'h0, 4);
         rc(ADDR_COUNT, 32'h0);
      end
      // Inverting A alone turns forward travel into down counts
      wr(ADDR_CTRL, 32'h18);
      repeat (20) @(posedge clk);
      wr(ADDR_COUNT, 32'h0);
      ecc_enc_model_inst.quad(1'h1, 4);
      rc(ADDR_COUNT, 32'hFFFF_FFFC);
      $display("test quadrature done");
   endtask : t_quad
   task automatic t_cmp;
      wr(ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      wr(ADDR_CMP, 32'hA);
      wr(ADDR_TRIG_W, 32'h5);
      wr(ADDR_COUNT, 32'h9);
      wr(ADDR_MASK, 32'h1);
      tcnt = 0;
      pin(4'h1, 20);
      pin(4'h0, 20);
      `CHK("trig cycles", 5, tcnt)
      rc(ADDR_STAT, 32'h1);
      `CHK("irq", 1'h1, irq)
      wr(ADDR_STAT, 32'h1);
      @(negedge clk);
      `CHK("irq", 1'h0, irq)
      $display("test compare done");
   endtask : t_cmp
   task automatic t_home;
      wr(ADDR_CTRL, 32'h200);
      wr(ADDR_HOME, 32'h2);
      wr(ADDR_COUNT, 32'h7);
      pin(4'h4, 20);
      pin(4'h0, 20);
      rc(ADDR_COUNT, 32'h7);
      pin(4'h4, 20);
      pin(4'h0, 20);
      rc(ADDR_COUNT, 32'h0);
      rc(ADDR_STAT, 32'h2);
      // Down travel through all-make must not clear until armed
      wr(ADDR_CTRL, 32'h108);
      wr(ADDR_COUNT, 32'h5);
      pin(4'h4, 20);
      ecc_enc_model_inst.quad(1'h0, 4);
      rc(ADDR_COUNT, 32'h1);
      pin(4'hC, 20);
      pin(4'h4, 20);
      ecc_enc_model_inst.quad(1'h0, 2);
      rc(ADDR_COUNT, 32'h0);
      $display("test homing done");
   endtask : t_home
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'h1;
      t_reset;
      t_filt;
      t_single;
      t_quad;
      t_cmp;
      t_home;
      close_out;
   end
   // Whole run is about two thousand cycles; this only cuts a hang
   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      close_out;
   end
endmodule : ecc_top_bench
bind ecc_top ecc_chk ecc_chk_inst (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .O_TRIG(O_TRIG), .O_IRQ(O_IRQ));

// [rtl/ecc_decoder.sv]
// Count decoder: quadrature x1/x2/x4, dual pulse and single pulse
`timescale 1ns/1ps
module ecc_decoder
   import ecc_pkg::*;
(
   input  wire logic      I_CLK,
   input  wire logic      I_RST_B,
   input  wire logic      i_a,
   input  wire logic      i_b,
   input  wire ecc_mode_t i_mode,
   input  wire ecc_rate_t i_rate,
   output logic           o_up,
   output logic           o_dn
);

   typedef struct packed {
      logic a;
      logic b;
   } ecc_dec_st_t;

   ecc_dec_st_t st_r;
   ecc_dec_st_t st_nxt;
   logic        a_ed;
   logic        b_ed;
   logic        a_rise;
   logic        fwd;

   assign a_ed   = i_a ^ st_r.a;
   assign b_ed   = i_b ^ st_r.b;
   assign a_rise = i_a & ~st_r.a;
   // A leading B: after an A edge, A differs from B
   assign fwd    = a_ed ? (i_a != i_b) : (i_a == i_b);

   always_comb
   begin
      st_nxt.a = i_a;
      st_nxt.b = i_b;
      o_up     = 1'b0;
      o_dn     = 1'b0;
      unique case (i_mode)
         ECC_QUAD:
         begin
            if (a_ed ^ b_ed)
            begin
               unique case (i_rate)
                  ECC_X4:
                  begin
                     o_up = fwd;
                     o_dn = ~fwd;
                  end
                  ECC_X2:
                  begin
                     o_up = a_ed & fwd;
                     o_dn = a_ed & ~fwd;
                  end
                  default:
                  begin
                     // One step per cycle, at A rise with B low going up
                     o_up = a_rise & ~i_b;
                     o_dn = a_ed & ~i_a & ~i_b;
                  end
               endcase
            end
         end
         ECC_DUAL:
         begin
            o_up = a_rise & ~(i_b & ~st_r.b);
            o_dn = (i_b & ~st_r.b) & ~a_rise;
         end
         default:
         begin
            o_up = a_rise & i_b;
            o_dn = a_rise & ~i_b;
         end
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

endmodule : ecc_decoder

// [rtl/ecc_filter.sv]
// Debounce filter: sync, sample at selected rate, accept stable two-sample level
`timescale 1ns/1ps
module ecc_filter
   import ecc_pkg::*;
#(
   parameter int unsigned NIN = 4
)(
   input  wire logic           I_CLK,
   input  wire logic           I_RST_B,
   input  wire logic [NIN-1:0] i_raw,
   input  wire logic [2:0]     i_sel,
   output logic      [NIN-1:0] o_clean
);

   function automatic logic [15:0] div_of(input logic [2:0] s);
      int unsigned k;
      k = (s < 3'(FILT_NSEL)) ? FILT_KHZ[s] : FILT_KHZ[1];
      return 16'((CLK_HZ / 1000 + k - 1) / k);
   endfunction : div_of

   typedef struct packed {
      logic [NIN-1:0] s1;
      logic [NIN-1:0] s2;
      logic [NIN-1:0] smp;
      logic [NIN-1:0] out;
      logic [15:0]    cnt;
   } ecc_flt_st_t;

   ecc_flt_st_t st_r;
   ecc_flt_st_t st_nxt;
   logic        tick;

   assign tick    = (st_r.cnt == 16'h0000);
   assign o_clean = st_r.out;

   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.s1  = i_raw;
      st_nxt.s2  = st_r.s1;
      st_nxt.cnt = tick ? 16'(div_of(i_sel) - 16'h0001) : 16'(st_r.cnt - 16'h0001);
      if (tick)
      begin
         // Level must hold two consecutive samples; shorter pulses vanish
         st_nxt.smp = st_r.s2;
         for (int i = 0; i < NIN; i++)
         begin
            if (st_r.s2[i] == st_r.smp[i])
               st_nxt.out[i] = st_r.smp[i];
         end
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

endmodule : ecc_filter

// [rtl/ecc_pkg.sv]
// Package: register map, field layout, reset values and timing for the encoder counter
package ecc_pkg;

   localparam int unsigned CLK_HZ          = 40_000_000;

   // Register byte offsets
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_FILT       = 8'h04;
   localparam logic [7:0]  ADDR_COUNT      = 8'h08;
   localparam logic [7:0]  ADDR_CMP        = 8'h0C;
   localparam logic [7:0]  ADDR_TRIG_W     = 8'h10;
   localparam logic [7:0]  ADDR_HOME       = 8'h14;
   localparam logic [7:0]  ADDR_STAT       = 8'h18;
   localparam logic [7:0]  ADDR_MASK       = 8'h1C;
   localparam logic [7:0]  ADDR_INPUTS     = 8'h20;

   // Control field positions
   localparam int unsigned CTRL_MODE_LSB   = 0;
   localparam int unsigned CTRL_RATE_LSB   = 2;
   localparam int unsigned CTRL_POL_LSB    = 4;
   localparam int unsigned CTRL_HMODE_LSB  = 8;
   localparam int unsigned CTRL_CLR_BIT    = 12;
   localparam int unsigned CTRL_ARM_BIT    = 13;

   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
   localparam logic [2:0]  FILT_RST        = 3'h1;
   localparam logic [31:0] TRIG_W_RST      = 32'h0000_0028;
   localparam logic [15:0] HOME_CNT_RST    = 16'h0001;

   // Status bits
   localparam int unsigned ST_MATCH        = 0;
   localparam int unsigned ST_HOMED        = 1;
   localparam int unsigned ST_NBITS        = 2;

   // Filter sampling: 512K,1M,2M,4M,8M,16M in kHz
   localparam int unsigned FILT_NSEL       = 6;
   localparam int unsigned FILT_KHZ [FILT_NSEL] = '{512, 1000, 2000, 4000, 8000, 16000};

   // Minimum pulse accepted at default setting
   localparam int unsigned MIN_PULSE_NS    = 1000;

   typedef enum logic [1:0] {ECC_QUAD, ECC_DUAL, ECC_SINGLE} ecc_mode_t;
   typedef enum logic [1:0] {ECC_X1, ECC_X2, ECC_X4} ecc_rate_t;
   typedef enum logic [1:0] {ECC_HOME_OFF, ECC_HOME_SW, ECC_HOME_IDX} ecc_hmode_t;

endpackage : ecc_pkg

// [rtl/ecc_top.sv]
// Encoder counter channel with AHB-Lite register slave, homing and compare trigger
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Quadrature counts up when A leads B
// - Quadrature steps follow x4, x2, x1
// - Dual pulse: CW pulse adds one
// - Dual pulse: CCW pulse subtracts one
// - Single pulse: clock adds one, direction make
// - Single pulse: clock subtracts one, direction break
// - Reset filter at 1M rejects sub-1us pulses
// - Filter rate selectable among six settings
// - Per-input polarity inversion before decoder
// - Home switch break, then clear at ABZ down
// - Index mode clears when Z counter hits zero
// - Compare match gives trigger of programmed width
module ecc_top
   import ecc_pkg::*;
#(
   parameter int unsigned CW = 32
)(
   input  wire logic        I_CLK,
   input  wire logic        I_RST_B,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        I_PHASE_A,
   input  wire logic        I_PHASE_B,
   input  wire logic        I_PHASE_Z,
   input  wire logic        I_HOME_SW,
   output logic             O_TRIG,
   output logic             O_IRQ
);

   typedef struct packed {
      logic            wr_pend;
      logic            rd_pend;
      logic [7:0]      addr;
      logic [31:0]     rdata;
      logic [31:0]     ctrl;
      logic [2:0]      filt;
      logic [CW-1:0]   count;
      logic [CW-1:0]   cmp;
      logic [31:0]     trig_w;
      logic [15:0]     home_cnt;
      logic [15:0]     z_left;
      logic            home_armed;
      logic            clr_pend;
      logic            z_prev;
      logic            home_prev;
      logic            cmp_hit;
      logic [31:0]     trig_cnt;
      logic            trig;
      logic [ST_NBITS-1:0] stat;
      logic [ST_NBITS-1:0] mask;
   } ecc_st_t;

   ecc_st_t    st_r;
   ecc_st_t    st_nxt;
   logic [3:0] raw;
   logic [3:0] clean;
   logic [3:0] pol;
   logic [3:0] lvl;
   logic       step_up;
   logic       step_dn;
   logic       z_rise;
   logic       home_brk;
   logic       abz_all;
   logic       match;
   logic [ST_NBITS-1:0] ev;
   ecc_mode_t  mode;
   ecc_rate_t  rate;
   ecc_hmode_t hmode;
   logic       acc;
   logic [31:0] rd_word;

   assign raw   = {I_HOME_SW, I_PHASE_Z, I_PHASE_B, I_PHASE_A};
   assign pol   = st_r.ctrl[CTRL_POL_LSB +: 4];
   assign mode  = ecc_mode_t'(st_r.ctrl[CTRL_MODE_LSB +: 2]);
   assign rate  = ecc_rate_t'(st_r.ctrl[CTRL_RATE_LSB +: 2]);
   assign hmode = ecc_hmode_t'(st_r.ctrl[CTRL_HMODE_LSB +: 2]);

   // Pins are synchronised inside the filter before anything reads them
   ecc_filter #(
      .NIN     (4)
   ) u_filter (
      .I_CLK   (I_CLK),
      .I_RST_B (I_RST_B),
      .i_raw   (raw),
      .i_sel   (st_r.filt),
      .o_clean (clean)
   );

   // Inverting one phase swaps apparent lead and lag
   assign lvl = clean ^ pol;

   ecc_decoder u_decoder (
      .I_CLK   (I_CLK),
      .I_RST_B (I_RST_B),
      .i_a     (lvl[0]),
      .i_b     (lvl[1]),
      .i_mode  (mode),
      .i_rate  (rate),
      .o_up    (step_up),
      .o_dn    (step_dn)
   );

   assign z_rise   = lvl[2] & ~st_r.z_prev;
   assign home_brk = ~lvl[3] & st_r.home_prev;
   assign abz_all  = lvl[0] & lvl[1] & lvl[2];
   assign match    = (st_r.count == st_r.cmp);
   assign acc      = HSEL & HREADY & HTRANS[1];

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = st_r.rdata;
   assign O_TRIG    = st_r.trig;
   assign O_IRQ     = |(st_r.stat & st_r.mask);

   // Read word picked in the address phase, values as of that edge
   always_comb
   begin
      unique case (HADDR[7:0])
         ADDR_CTRL:
         begin
            rd_word = st_r.ctrl;
         end
         ADDR_FILT:
         begin
            rd_word = {29'h0, st_r.filt};
         end
         ADDR_COUNT:
         begin
            rd_word = 32'(st_r.count);
         end
         ADDR_CMP:
         begin
            rd_word = 32'(st_r.cmp);
         end
         ADDR_TRIG_W:
         begin
            rd_word = st_r.trig_w;
         end
         ADDR_HOME:
         begin
            rd_word = {st_r.z_left, st_r.home_cnt};
         end
         ADDR_STAT:
         begin
            rd_word = 32'(st_r.stat);
         end
         ADDR_MASK:
         begin
            rd_word = 32'(st_r.mask);
         end
         ADDR_INPUTS:
         begin
            // Levels after polarity, so software sees what the decoder sees
            rd_word = {27'h0, st_r.trig, lvl};
         end
         default:
         begin
            // Unmapped offsets read as zero
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_comb
   begin
      st_nxt           = st_r;
      ev               = '0;
      st_nxt.z_prev    = lvl[2];
      st_nxt.home_prev = lvl[3];
      st_nxt.clr_pend  = 1'b0;
      st_nxt.ctrl[CTRL_CLR_BIT] = 1'b0;
      st_nxt.ctrl[CTRL_ARM_BIT] = 1'b0;

      // Counting; a pending clear takes priority over the step
      // A step landing in the clear cycle is lost
      if (st_r.clr_pend || st_r.ctrl[CTRL_CLR_BIT])
      begin
         st_nxt.count = '0;
      end
      else if (step_up)
      begin
         st_nxt.count = CW'(st_r.count + CW'(1));
      end
      else if (step_dn)
      begin
         st_nxt.count = CW'(st_r.count - CW'(1));
      end

      unique case (hmode)
         ECC_HOME_SW:
         begin
            // Arm on break; only the next all-make down step clears
            if (home_brk)
            begin
               st_nxt.home_armed = 1'b1;
            end
            if (st_r.home_armed && abz_all && step_dn)
            begin
               st_nxt.clr_pend   = 1'b1;
               st_nxt.home_armed = 1'b0;
               ev[ST_HOMED]      = 1'b1;
            end
         end
         ECC_HOME_IDX:
         begin
            // Each Z rise spends one; stops at zero until reloaded
            if (z_rise && st_r.z_left != 16'h0000)
            begin
               st_nxt.z_left = 16'(st_r.z_left - 16'h0001);
               if (st_r.z_left == 16'h0001)
               begin
                  st_nxt.clr_pend = 1'b1;
                  ev[ST_HOMED]    = 1'b1;
               end
            end
         end
         default:
         begin
            st_nxt.home_armed = 1'b0;
         end
      endcase

      // Rising match only, so a stationary axis fires once
      st_nxt.cmp_hit = match;
      if (st_r.trig_cnt != 32'h0)
      begin
         st_nxt.trig_cnt = 32'(st_r.trig_cnt - 32'h1);
      end
      if (match && !st_r.cmp_hit && st_r.trig_w != 32'h0)
      begin
         st_nxt.trig_cnt = st_r.trig_w;
         ev[ST_MATCH]    = 1'b1;
      end
      st_nxt.trig = (st_nxt.trig_cnt != 32'h0);

      // Bus data phase
      st_nxt.rd_pend = 1'b0;
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_pend)
      begin
         unique case (st_r.addr)
            ADDR_CTRL:
            begin
               st_nxt.ctrl = HWDATA;
            end
            ADDR_FILT:
            begin
               st_nxt.filt = HWDATA[2:0];
            end
            ADDR_COUNT:
            begin
               // A bus write beats a step in the same cycle
               st_nxt.count = HWDATA[CW-1:0];
            end
            ADDR_CMP:
            begin
               st_nxt.cmp = HWDATA[CW-1:0];
            end
            ADDR_TRIG_W:
            begin
               st_nxt.trig_w = HWDATA;
            end
            ADDR_HOME:
            begin
               st_nxt.home_cnt = HWDATA[15:0];
            end
            ADDR_STAT:
            begin
               st_nxt.stat = st_r.stat & ~HWDATA[ST_NBITS-1:0];
            end
            ADDR_MASK:
            begin
               st_nxt.mask = HWDATA[ST_NBITS-1:0];
            end
            ADDR_INPUTS:
            begin
               // Read only; the write is dropped
               st_nxt.rdata = st_r.rdata;
            end
            default:
            begin
               st_nxt.rdata = st_r.rdata;
            end
         endcase
         if (st_r.addr == ADDR_CTRL && HWDATA[CTRL_ARM_BIT])
         begin
            st_nxt.z_left = st_nxt.home_cnt;
         end
      end
      // Writing the reload count also restarts the index countdown
      if (st_r.addr == ADDR_HOME && st_r.wr_pend)
      begin
         st_nxt.z_left = HWDATA[15:0];
      end

      // Events win over a write-one clear
      st_nxt.stat = st_nxt.stat | ev;

      if (acc)
      begin
         st_nxt.addr    = HADDR[7:0];
         st_nxt.wr_pend = HWRITE;
         st_nxt.rd_pend = ~HWRITE;
         // Registered so HRDATA stands through the data phase
         st_nxt.rdata   = rd_word;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         st_r          <= '0;
         st_r.ctrl     <= CTRL_RST;
         st_r.filt     <= FILT_RST;
         st_r.trig_w   <= TRIG_W_RST;
         st_r.home_cnt <= HOME_CNT_RST;
         st_r.z_left   <= HOME_CNT_RST;
         st_r.cmp      <= {CW{1'b1}};
      end
      else
         st_r <= st_nxt;
   end

endmodule : ecc_top
